/* edcu_consts.vh */
`ifndef EDCU_CONSTS_VH
`define EDCU_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EDCU_OFF_CTRL      12'h000
`define EDCU_OFF_SYS_DATA  12'h004
`define EDCU_OFF_DIAG      12'h008
`define EDCU_OFF_CORR_DATA 12'h00c
`define EDCU_OFF_STATUS    12'h010
`define EDCU_OFF_CB_OUT    12'h014

// ----------------------------------------
// Control word layout (also the diag control field)
// ----------------------------------------
`define EDCU_CTL_CORRECT   0
`define EDCU_CTL_OLOAD     1
`define EDCU_CTL_ILOAD     2
`define EDCU_CTL_DSEL_LO   3
`define EDCU_CTL_CODE_LO   5
`define EDCU_CTL_DLOAD     7
`define EDCU_CTL_OEN       8
`define EDCU_CTL_BSEL_LO   12
`define EDCU_CTL_RESET     32'h0000_0104

// ----------------------------------------
// Diagnostic latch layout
// ----------------------------------------
`define EDCU_DIAG_CB_LO    0
`define EDCU_DIAG_CTL_LO   8
`define EDCU_DIAG_RESET    32'h0000_0000

// ----------------------------------------
// Diagnostic select codes
// ----------------------------------------
`define EDCU_DSEL_NORMAL   2'b00
`define EDCU_DSEL_DIAG     2'b01
`define EDCU_DSEL_PASS     2'b10
`define EDCU_DSEL_INTERNAL 2'b11

// ----------------------------------------
// Status layout
// ----------------------------------------
`define EDCU_ST_SYN_LO     0
`define EDCU_ST_ERR        8
`define EDCU_ST_MULT       9
`define EDCU_ST_TWO        10
`define EDCU_ST_SINGLE     11
`define EDCU_ST_INTERNAL   12

`endif

/* edcu_unit.v */
// What this block does
// - Check-bit in, check-bit out and syndrome share one bus.
// - One control selects generate and loads the output latch.
// - Input latch is transparent while its load input is high.
// - Detect mode flags errors but passes data uncorrected.
// - Diagnostic latch has a check-bit field and a control field.
// - Diag check bits replace generated or memory check bits.
// - Control field is ignored outside internal control mode.
// - In internal control mode control field replaces each control input except the byte selects.
// - Correct mode from correct input or from control-field correct bit.
// - Pass-through moves data unaltered, no checking or correction.
// - Raw check-bit memory contents reach the data bus only via the check-bit register in pass-through.
// - Full-word write generates check bits and drives them to memory.
// - Read and first partial-write phase both run in correct mode.
// - Correct-regenerate equals partial-write second phase but byte selects.
// - 7-bit syndrome: zero is no error, one set bit a check bit.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "edcu_consts.vh"

module edcu_unit (
   input  wire        mclk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [31:0] mem_data_in,
   output reg  [31:0] mem_data_out,
   output reg  [3:0]  mem_data_oe_n,
   input  wire [6:0]  cb_bus_in,
   output reg  [6:0]  cb_bus_out,
   output reg         cb_bus_oe_n,
   output reg         error_flag,
   output reg         mult_error_flag
);

   // ----------------------------------------
   // Syndrome code of each data bit
   // ----------------------------------------
   function [6:0] edcu_bit_syn;
      input [4:0] idx;
      begin
         case (idx)
            5'd0:    edcu_bit_syn = 7'h4f;
            5'd1:    edcu_bit_syn = 7'h4a;
            5'd2:    edcu_bit_syn = 7'h52;
            5'd3:    edcu_bit_syn = 7'h54;
            5'd4:    edcu_bit_syn = 7'h57;
            5'd5:    edcu_bit_syn = 7'h58;
            5'd6:    edcu_bit_syn = 7'h5b;
            5'd7:    edcu_bit_syn = 7'h5d;
            5'd8:    edcu_bit_syn = 7'h23;
            5'd9:    edcu_bit_syn = 7'h25;
            5'd10:   edcu_bit_syn = 7'h26;
            5'd11:   edcu_bit_syn = 7'h29;
            5'd12:   edcu_bit_syn = 7'h2a;
            5'd13:   edcu_bit_syn = 7'h2c;
            5'd14:   edcu_bit_syn = 7'h31;
            5'd15:   edcu_bit_syn = 7'h34;
            5'd16:   edcu_bit_syn = 7'h0e;
            5'd17:   edcu_bit_syn = 7'h0b;
            5'd18:   edcu_bit_syn = 7'h13;
            5'd19:   edcu_bit_syn = 7'h15;
            5'd20:   edcu_bit_syn = 7'h16;
            5'd21:   edcu_bit_syn = 7'h19;
            5'd22:   edcu_bit_syn = 7'h1a;
            5'd23:   edcu_bit_syn = 7'h1c;
            5'd24:   edcu_bit_syn = 7'h62;
            5'd25:   edcu_bit_syn = 7'h64;
            5'd26:   edcu_bit_syn = 7'h67;
            5'd27:   edcu_bit_syn = 7'h68;
            5'd28:   edcu_bit_syn = 7'h6b;
            5'd29:   edcu_bit_syn = 7'h6d;
            5'd30:   edcu_bit_syn = 7'h70;
            default: edcu_bit_syn = 7'h75;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Check-bit generation from the column codes
   // ----------------------------------------
   function [6:0] edcu_gen;
      input [31:0] d;
      integer i;
      begin
         edcu_gen = 7'h00;
         for (i = 0; i < 32; i = i + 1) begin
            if (d[i]) begin
               edcu_gen = edcu_gen ^ edcu_bit_syn(i[4:0]);
            end
         end
      end
   endfunction

   // ----------------------------------------
   // Data bit flip mask for a syndrome
   // ----------------------------------------
   function [31:0] edcu_fix_mask;
      input [6:0] s;
      integer i;
      begin
         edcu_fix_mask = 32'h0000_0000;
         for (i = 0; i < 32; i = i + 1) begin
            edcu_fix_mask[i] = (s == edcu_bit_syn(i[4:0]));
         end
      end
   endfunction

   // ----------------------------------------
   // Registers and synchronisers
   // ----------------------------------------
   reg  [31:0] ctrl;
   reg  [31:0] sys_data;
   reg  [6:0]  diag_cb;
   reg  [8:0]  diag_ctl;
   reg  [31:0] mem_meta;
   reg  [31:0] mem_sync;
   reg  [6:0]  cb_meta;
   reg  [6:0]  cb_sync;
   reg  [31:0] in_data;
   reg  [6:0]  in_cb;
   reg  [31:0] out_data;
   reg  [6:0]  out_cb;
   reg  [6:0]  syn_q;
   reg         two_q;
   reg         single_q;
   // Reset image of the diag latch, split into its two fields on reset
   wire [31:0] diag_rst = `EDCU_DIAG_RESET;

   wire        internal_mode;
   wire [8:0]  ctl_eff;
   wire        eff_correct;
   wire        eff_oload;
   wire        eff_iload;
   wire [1:0]  eff_dsel;
   wire        eff_dload;
   wire        eff_oen;
   wire        pass_mode;
   wire        diag_mode;
   wire [3:0]  byte_sel;
   wire        apb_write;
   wire        apb_access;

   reg  [31:0] next_in_data;
   reg  [6:0]  next_cb_used;
   reg  [6:0]  next_syn;
   reg  [31:0] next_word;
   reg  [6:0]  next_gen_cb;
   reg         next_err;
   reg         next_two;
   reg         next_onehot;
   reg         next_mult;
   reg  [31:0] next_rdata;
   reg         next_slverr;
   integer     b;

   // ----------------------------------------
   // Effective controls
   // ----------------------------------------
   // Internal mode is entered from the control word select only
   assign internal_mode = (ctrl[`EDCU_CTL_DSEL_LO +: 2] == `EDCU_DSEL_INTERNAL);
   assign ctl_eff = internal_mode ? diag_ctl : ctrl[8:0];
   assign eff_correct = ctl_eff[`EDCU_CTL_CORRECT];
   assign eff_oload = ctl_eff[`EDCU_CTL_OLOAD];
   assign eff_iload = ctl_eff[`EDCU_CTL_ILOAD];
   assign eff_dsel  = ctl_eff[`EDCU_CTL_DSEL_LO +: 2];
   assign eff_dload = ctl_eff[`EDCU_CTL_DLOAD];
   assign eff_oen   = ctl_eff[`EDCU_CTL_OEN];
   assign pass_mode = (eff_dsel == `EDCU_DSEL_PASS);
   assign diag_mode = (eff_dsel == `EDCU_DSEL_DIAG);
   assign byte_sel  = ctrl[`EDCU_CTL_BSEL_LO +: 4];

   // Zero-wait is not possible: answer is registered, one wait state
   assign apb_access = psel & penable;
   assign apb_write  = apb_access & pwrite & pready;

   // ----------------------------------------
   // Datapath combinational logic
   // ----------------------------------------
   always @* begin
      for (b = 0; b < 4; b = b + 1) begin
         next_in_data[b*8 +: 8] = byte_sel[b] ? sys_data[b*8 +: 8] : mem_sync[b*8 +: 8];
      end
      next_cb_used = diag_mode ? diag_cb : in_cb;
      next_syn    = edcu_gen(in_data) ^ next_cb_used;
      next_err    = (next_syn != 7'h00);
      next_onehot = ((next_syn & (next_syn - 7'h01)) == 7'h00);
      next_two    = next_err & ~(^next_syn);
      // odd codes off the table, other than one-hot, are multiple
      next_mult   = next_err & (^next_syn) & ~next_onehot
                    & (edcu_fix_mask(next_syn) == 32'h0000_0000);
      if (eff_correct & ~pass_mode) begin
         next_word = in_data ^ edcu_fix_mask(next_syn);
      end else begin
         next_word = in_data;
      end
      if (pass_mode) begin
         next_syn  = 7'h00;
         next_err  = 1'b0;
         next_two  = 1'b0;
         next_mult = 1'b0;
      end
      // check bits from the written word, or diag bits in diag mode, or raw memory bits in pass-through
      if (diag_mode) begin
         next_gen_cb = diag_cb;
      end else if (pass_mode) begin
         next_gen_cb = in_cb;
      end else begin
         next_gen_cb = edcu_gen(next_word);
      end
   end

   // ----------------------------------------
   // Input stage: synchronisers and latch
   // ----------------------------------------
   always @(posedge mclk) begin
      mem_meta <= mem_data_in;
      mem_sync <= mem_meta;
      cb_meta  <= cb_bus_in;
      cb_sync  <= cb_meta;
      if (rst) begin
         in_data <= 32'h0000_0000;
         in_cb   <= 7'h00;
      end else if (eff_iload) begin
         in_data <= next_in_data;
         in_cb   <= cb_sync;
      end
   end

   // ----------------------------------------
   // Output latch, flags and memory-side pins
   // ----------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         out_data        <= 32'h0000_0000;
         out_cb          <= 7'h00;
         syn_q           <= 7'h00;
         two_q           <= 1'b0;
         single_q        <= 1'b0;
         error_flag      <= 1'b0;
         mult_error_flag <= 1'b0;
         mem_data_out    <= 32'h0000_0000;
         mem_data_oe_n   <= 4'hf;
         cb_bus_out      <= 7'h00;
         cb_bus_oe_n     <= 1'b1;
      end else begin
         // Flags are meaningless while generating, so kept clear
         syn_q           <= eff_oload ? 7'h00 : next_syn;
         two_q           <= ~eff_oload & next_two;
         single_q        <= ~eff_oload & next_err & ~next_two & ~next_mult;
         error_flag      <= ~eff_oload & next_err;
         mult_error_flag <= ~eff_oload & next_mult;
         if (eff_oload) begin
            out_data     <= next_word;
            out_cb       <= next_gen_cb;
            mem_data_out <= next_word;
         end
         mem_data_oe_n <= eff_oload ? 4'h0 : 4'hf;
         cb_bus_out  <= eff_oload ? next_gen_cb : next_syn;
         cb_bus_oe_n <= eff_oen;
      end
   end

   // ----------------------------------------
   // APB register writes and diag latch load
   // ----------------------------------------
   always @(posedge mclk) begin
      if (rst) begin
         ctrl     <= `EDCU_CTL_RESET;
         sys_data <= 32'h0000_0000;
         diag_cb  <= diag_rst[`EDCU_DIAG_CB_LO +: 7];
         diag_ctl <= diag_rst[`EDCU_DIAG_CTL_LO +: 9];
      end else begin
         if (apb_write && paddr == `EDCU_OFF_CTRL) begin
            ctrl <= pwdata & 32'h0000_f1ff;
         end
         if (apb_write && paddr == `EDCU_OFF_SYS_DATA) begin
            sys_data <= pwdata;
         end
         if (eff_dload) begin
            diag_cb  <= sys_data[`EDCU_DIAG_CB_LO +: 7];
            diag_ctl <= sys_data[`EDCU_DIAG_CTL_LO +: 9];
         end
      end
   end

   // ----------------------------------------
   // APB read mux and answer
   // ----------------------------------------
   always @* begin
      next_rdata  = 32'h0000_0000;
      next_slverr = 1'b0;
      case (paddr)
         `EDCU_OFF_CTRL:      next_rdata = ctrl;
         `EDCU_OFF_SYS_DATA:  next_rdata = sys_data;
         `EDCU_OFF_DIAG:      next_rdata = {15'h0000, diag_ctl, 1'b0, diag_cb};
         `EDCU_OFF_CORR_DATA: next_rdata = out_data;
         `EDCU_OFF_STATUS:    next_rdata = {19'h00000, internal_mode, single_q,
                                            two_q, mult_error_flag, error_flag,
                                            1'b0, syn_q};
         // generated bits, diag bits in diag mode, or raw memory bits latched in pass-through
         `EDCU_OFF_CB_OUT:    next_rdata = {25'h0000000, out_cb};
         default:             next_slverr = 1'b1;
      endcase
   end

   // Answer after one wait cycle; pready drops right after completion
   always @(posedge mclk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= apb_access & ~pready;
         prdata  <= (apb_access & ~pready & ~pwrite) ? next_rdata : 32'h0000_0000;
         pslverr <= apb_access & ~pready & next_slverr;
      end
   end

endmodule // edcu_unit

/* edcu_unit_monitor.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port watcher for the edc unit
// ----------------------------------------
module edcu_unit_monitor (
   input wire        mclk,
   input wire        rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire [3:0]  mem_data_oe_n,
   input wire        cb_bus_oe_n,
   input wire        error_flag,
   input wire        mult_error_flag
);
   // Control write and status read, taken at the answering edge
   wire ctl_wr = pready & psel & penable & pwrite & (paddr == 12'h000) & !pslverr;
   wire ext_wr = ctl_wr & (pwdata[4:3] != 2'b11);
   wire st_rd  = pready & psel & penable & !pwrite & (paddr == 12'h010);
   wire mapped = (paddr[1:0] == 2'b00) & (paddr <= 12'h014);

   default clocking mon_clk @(posedge mclk); endclocking
   default disable iff (rst);

   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   AST_ONE_WAIT: assert property (psel & penable & !pready |=> pready)
      else $error("access not answered after one wait state");
   AST_UNMAPPED: assert property (pready & psel & penable |-> pslverr == !mapped)
      else $error("slave error does not match the address map");
   AST_RESET_OE: assert property ($past(rst) |-> mem_data_oe_n == 4'hf && cb_bus_oe_n)
      else $error("drivers enabled right after reset");
   AST_OE_FOLLOWS: assert property (ext_wr |=> ##1 cb_bus_oe_n == $past(pwdata[8], 2))
      else $error("check-bit bus enable does not follow control word");
   AST_LOAD_DRIVES: assert property (
      ext_wr & pwdata[1] & (pwdata[15:12] == 4'hf) |=> ##1 mem_data_oe_n == 4'h0)
      else $error("output latch load did not enable data drivers");
   AST_NO_LOAD_OFF: assert property (ext_wr & !pwdata[1] |=> ##1 mem_data_oe_n == 4'hf)
      else $error("data drivers on without output latch load");
   AST_PASS_QUIET: assert property (ctl_wr & (pwdata[4:3] == 2'b10) |=> ##2 !error_flag)
      else $error("error flag raised in pass-through");
   AST_GEN_QUIET: assert property (ext_wr & pwdata[1] |=> ##2 !error_flag)
      else $error("error flag raised while generating");
   AST_MULT_IS_ERR: assert property (mult_error_flag |-> error_flag)
      else $error("multiple error without error flag");
   AST_ZERO_SYN: assert property (st_rd & (prdata[6:0] == 7'h00) |-> prdata[11:8] == 4'h0)
      else $error("zero syndrome reported as an error");
   AST_EVEN_TWO: assert property (
      st_rd & prdata[8] & !(^prdata[6:0]) |-> prdata[10] & !prdata[9] & !prdata[11])
      else $error("even syndrome not decoded as two errors");
endmodule // edcu_unit_monitor

bind edcu_unit edcu_unit_monitor mon (.*);

/* edcu_mem_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Main and check-bit memory, one location
// ----------------------------------------
module edcu_mem_model (
   input  wire        mclk,
   input  wire        we,
   input  wire [31:0] err_mask,
   input  wire [6:0]  cb_err,
   input  wire [31:0] mem_data_out,
   input  wire [3:0]  mem_data_oe_n,
   input  wire [6:0]  cb_bus_out,
   input  wire        cb_bus_oe_n,
   output wire [31:0] mem_data_in,
   output wire [6:0]  cb_bus_in,
   output reg  [31:0] word,
   output reg  [6:0]  cbits
);
   integer b;
   wire [31:0] rel = {{8{mem_data_oe_n[3]}}, {8{mem_data_oe_n[2]}},
                      {8{mem_data_oe_n[1]}}, {8{mem_data_oe_n[0]}}};
   // fixed initial value
   // Zero word with zero check bits, so a first read comes back clean
   initial begin
      word  = 32'h0000_0000;
      cbits = 7'h00;
   end
   // per-byte enables
   // Only bytes and check bits the unit drives are stored
   always @(posedge mclk) begin
      if (we) begin
         for (b = 0; b < 4; b = b + 1)
            if (!mem_data_oe_n[b]) word[8*b +: 8] <= mem_data_out[8*b +: 8];
         if (!cb_bus_oe_n) cbits <= cb_bus_out;
      end
   end
   // Wire levels: unit's drive wins, else memory reads out with injected faults
   assign mem_data_in = (mem_data_out & ~rel) | ((word ^ err_mask) & rel);
   assign cb_bus_in   = cb_bus_oe_n ? (cbits ^ cb_err) : cb_bus_out;
endmodule // edcu_mem_model

/* edcu_unit_tb.sv */
`timescale 1ns/1ps
module edcu_unit_tb;
   reg         mclk, rst, psel, penable, pwrite, we;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, err_mask, d, s, x;
   reg  [6:0]  cb_err, syn, ce;
   wire [31:0] prdata, mem_data_in, mem_data_out, word;
   wire        pready, pslverr, cb_bus_oe_n, error_flag, mult_error_flag;
   wire [3:0]  mem_data_oe_n;
   wire [6:0]  cb_bus_in, cb_bus_out, cbits;
   integer     err_count, comparisons, seed, k, b, j;
   reg  [32:0] exp_q[$], msk_q[$];
   string      nam_q[$];
   // Syndrome column of each data bit, bit 0 in the low byte
   localparam [255:0] syn_cols = 256'h75706d6b_68676462_1c1a1916_15130b0e_34312c2a_29262523_5d5b5857_54524a4f;
   localparam settle = 4; // two sync flops, input latch, result register

   edcu_unit dut (.*);
   edcu_mem_model mem (.*);

   // ----------------------------------------
   // Clock, helpers, answer watcher
   // ----------------------------------------
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;

   function [6:0] gen(input [31:0] v);
      integer i;
      begin
         gen = 7'h00;
         for (i = 0; i < 32; i = i + 1)
            if (v[i]) gen = gen ^ syn_cols[8*i +: 7];
      end
   endfunction
   // Width code always 00, so correct-regenerate keeps it there
   function [31:0] ctl(input [3:0] bs, input oen, dl, input [1:0] ds, input il, ol, c);
      ctl = {16'h0000, bs, 3'b000, oen, dl, 2'b00, ds, il, ol, c};
   endfunction
   task chk(input string n, input [32:0] e, input [32:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   // One transfer; its expected answer is queued for the watcher
   task apb(input wr, input [11:0] a, input [31:0] v, input [32:0] e, m, input string n);
      begin
         exp_q.push_back(e & m);
         msk_q.push_back(m);
         nam_q.push_back(n);
         @(posedge mclk);
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= v;
         @(posedge mclk);
         penable <= 1'b1;
         @(posedge mclk);
         // No fixed wait assumed; only the watchdog ends a hung access
         while (pready !== 1'b1) begin
            @(posedge mclk);
         end
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [11:0] a, input [31:0] v);
      apb(1'b1, a, v, 33'h0, 33'h1_0000_0000, "write answer");
   endtask
   task rd(input [11:0] a, input [31:0] e, input [31:0] m, input string n);
      apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m}, n);
   endtask
   // Control write, then wait out the datapath latency
   task setc(input [31:0] v);
      begin
         wr(12'h000, v);
         repeat (settle) @(posedge mclk);
      end
   endtask
   always @(posedge mclk) begin
      if (pready === 1'b1 && exp_q.size() > 0)
         chk(nam_q.pop_front(), exp_q.pop_front(), {pslverr, prdata} & msk_q.pop_front());
   end
   task tally_and_finish;
      begin
         $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
         if (err_count == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Watchdog well beyond the few hundred cycles needed
   initial begin
      #(8 * 20000);
      err_count = err_count + 1;
      tally_and_finish;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst, psel, penable, pwrite, we} = 5'b10000;
      {paddr, pwdata, err_mask, cb_err} = 0;
      {err_count, comparisons, seed} = {32'd0, 32'd0, 32'd39};
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rd(12'h000, 32'h0000_0104, 32'hffff_ffff, "ctrl reset");
      rd(12'h008, 32'h0, 32'hffff_ffff, "diag reset");
      apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0}, 33'h1_ffff_ffff, "unmapped read");
      apb(1'b1, 12'h020, 32'h5a5a_5a5a, {1'b1, 32'h0}, 33'h1_0000_0000, "unmapped write");
      // Store, read with each fault kind, then correct (detect when k >= 4) and regenerate
      for (k = 0; k < 8; k = k + 1) begin
         d = $random(seed);
         err_mask <= 32'h0;
         cb_err   <= 7'h00;
         wr(12'h004, d);
         setc(ctl(4'hf, 1'b0, 1'b0, 2'b00, 1'b1, 1'b1, 1'b0));
         chk("mem data out", {1'b0, d}, {1'b0, mem_data_out});
         chk("generated bits", {26'h0, gen(d)}, {26'h0, cb_bus_out});
         we <= 1'b1;
         @(posedge mclk);
         we <= 1'b0;
         rd(12'h014, {25'h0, gen(d)}, 32'hffff_ffff, "check bits reg");
         chk("stored bits", {26'h0, gen(d)}, {26'h0, cbits});
         b = {$random(seed)} % 31;
         j = k % 4;
         // Faults: none, one data bit, one check bit (three when detecting), two data bits
         s  = (j == 1) ? (32'h1 << b) : (j == 3) ? (32'h3 << b) : 32'h0;
         ce = (j != 2) ? 7'h00 : (k < 4) ? (7'h01 << (b % 7)) : 7'h07;
         err_mask <= s;
         cb_err   <= ce;
         syn = gen(s) ^ ce;
         // Check-bit drive off while correcting or detecting through an open latch
         setc(ctl(4'h0, 1'b1, 1'b0, 2'b00, 1'b1, 1'b0, k < 4));
         rd(12'h010, {20'h0, ^syn & (syn != 7'h07), (syn != 0) & ~^syn, syn == 7'h07,
            syn != 0, 1'b0, syn}, 32'h1fff, "status");
         chk("error pin", {32'h0, syn != 0}, {32'h0, error_flag});
         chk("mult pin", {32'h0, syn == 7'h07}, {32'h0, mult_error_flag});
         chk("syndrome on bus", {26'h0, syn}, {26'h0, cb_bus_out});
         setc(ctl(4'h0, 1'b0, 1'b0, 2'b00, 1'b0, 1'b1, k < 4));
         // Two-bit faults are beyond correction, so they stay in the word
         x = (k < 4 && j != 3) ? d : d ^ s;
         rd(12'h00c, x, 32'hffff_ffff, "output latch");
         chk("regen bits", {26'h0, gen(x)}, {26'h0, cb_bus_out});
      end
      // Pass-through in both directions, fault left in place
      err_mask <= 32'h0000_0100;
      cb_err   <= 7'h00;
      setc(ctl(4'h0, 1'b1, 1'b0, 2'b10, 1'b1, 1'b0, 1'b1));
      chk("pass error pin", 33'h0, {32'h0, error_flag});
      setc(ctl(4'h0, 1'b1, 1'b0, 2'b10, 1'b0, 1'b1, 1'b1));
      rd(12'h00c, d ^ 32'h100, 32'hffff_ffff, "pass read");
      s = $random(seed);
      wr(12'h004, s);
      setc(ctl(4'hf, 1'b1, 1'b0, 2'b10, 1'b1, 1'b1, 1'b0));
      chk("pass write", {1'b0, s}, {1'b0, mem_data_out});
      // Diag latch: check field 55, control field correct plus load
      wr(12'h004, 32'h0000_0355);
      setc(ctl(4'h0, 1'b1, 1'b1, 2'b00, 1'b0, 1'b0, 1'b0));
      rd(12'h008, 32'h0000_0355, 32'h0001_ff7f, "diag latch");
      setc(ctl(4'h0, 1'b1, 1'b0, 2'b01, 1'b1, 1'b0, 1'b0));
      rd(12'h010, {25'h0, gen(d ^ 32'h100) ^ 7'h55}, 32'h7f, "diag syndrome");
      setc(ctl(4'hf, 1'b0, 1'b0, 2'b01, 1'b1, 1'b1, 1'b0));
      chk("diag bits out", {26'h0, 7'h55}, {26'h0, cb_bus_out});
      // Latch a faulty word, then unload with and without internal control
      setc(ctl(4'h0, 1'b1, 1'b0, 2'b00, 1'b1, 1'b0, 1'b0));
      setc(ctl(4'h0, 1'b1, 1'b0, 2'b00, 1'b0, 1'b1, 1'b0));
      rd(12'h00c, d ^ 32'h100, 32'hffff_ffff, "field ignored");
      setc(ctl(4'h0, 1'b1, 1'b0, 2'b11, 1'b0, 1'b0, 1'b0));
      rd(12'h00c, d, 32'hffff_ffff, "internal correct");
      rd(12'h010, 32'h1000, 32'h1000, "internal flag");
      tally_and_finish;
   end
endmodule // edcu_unit_tb
